/* File: src/exec_timing_pkg.sv */
package exec_timing_pkg;

   // Decode of the four-byte bit-manipulation page
   localparam int          CODE_W          = 32;
   localparam int          REG_FIELD_LSB   = 20;
   localparam int          REG_FIELD_W     = 4;
   localparam int          ABS_FIELD_LSB   = 16;
   localparam int          ABS_FIELD_W     = 8;
   localparam int          NIBBLE_SEL_BIT  = 7;
   localparam logic [7:0]  PAGE_REG_A      = 8'h7C;
   localparam logic [7:0]  PAGE_REG_B      = 8'h7D;
   localparam logic [7:0]  PAGE_ABS_A      = 8'h7E;
   localparam logic [7:0]  PAGE_ABS_B      = 8'h7F;
   localparam logic [3:0]  PAGE_LOW_NIB    = 4'h0;
   localparam logic [3:0]  PAGE_LOW_NIB_6  = 4'h6;
   localparam logic [3:0]  PAGE_LOW_NIB_7  = 4'h7;

   // States per cycle category
   localparam int          CNT_W           = 4;
   localparam int          STATE_W         = 8;
   localparam logic [1:0]  STATES_MEM      = 2'h2;
   localparam logic [1:0]  STATES_PERIPH_2 = 2'h2;
   localparam logic [1:0]  STATES_PERIPH_3 = 2'h3;
   localparam logic [1:0]  STATES_INTERNAL = 2'h1;

   // Operand addressing of a decoded code
   typedef enum logic [1:0] {
      OPND_NONE,
      OPND_REG,
      OPND_ABS
   } opnd_kind_t;

endpackage

/* File: src/state_term.sv */
`timescale 1ns/1ps
// One product term: cycle count times states per cycle
module state_term #(
   parameter int CNT_W   = 4,
   parameter int STATE_W = 8
) (
   // Operands
   input  wire logic [CNT_W-1:0]   cycles_i,
   input  wire logic [1:0]         per_cycle_i,
   // Result
   output logic      [STATE_W-1:0] states_o
);

   if (STATE_W < CNT_W + 2) begin : g_bad_width
      $error("state_term: STATE_W too narrow");
   end

   always_comb begin
      states_o = STATE_W'(cycles_i) * STATE_W'(per_cycle_i);
   end

endmodule

/* File: src/cpu_execution_state_timing.sv */
`timescale 1ns/1ps
// Overview of operation
// - Top bit of upper nibble picks group
// - Register operand from register designation field
// - Memory operand from absolute address field
// - Total states: sum of count times states
// - Six cycle categories counted per instruction
// - Fetch, branch, stack on-chip: two states
// - Byte access to on-chip RAM: two states
// - Peripheral data access: two or three states
module cpu_execution_state_timing #(
   parameter int CNT_W   = exec_timing_pkg::CNT_W,
   parameter int STATE_W = exec_timing_pkg::STATE_W
) (
   // Clock and reset
   input  wire logic                mclk_i,
   input  wire logic                rst_b_i,
   // Instruction code, bytes 1..4 from msb down
   input  wire logic                code_valid_i,
   input  wire logic [31:0]         code_i,
   // Cycle counts: fetch, branch read, stack, byte, word, internal
   input  wire logic [CNT_W-1:0]    fetch_cnt_i,
   input  wire logic [CNT_W-1:0]    branch_cnt_i,
   input  wire logic [CNT_W-1:0]    stack_cnt_i,
   input  wire logic [CNT_W-1:0]    byte_cnt_i,
   input  wire logic [CNT_W-1:0]    word_cnt_i,
   input  wire logic [CNT_W-1:0]    internal_cnt_i,
   // Data access location: 1 = peripheral, then 3-state module
   input  wire logic                data_periph_i,
   input  wire logic                periph_slow_i,
   // Decode results
   output logic                     valid_o,
   output logic                     bit_page_o,
   output logic                     group_hi_o,
   output logic [1:0]               opnd_kind_o,
   output logic [3:0]               reg_num_o,
   output logic [7:0]               absolute_address_field_o,
   output logic [STATE_W-1:0]       exec_states_o
);

   // A zero-width count would leave the product terms undefined
   if (CNT_W < 1) begin : g_bad_cnt
      $error("cpu_execution_state_timing: CNT_W must be at least 1");
   end
   // Worst case total is 13 * (2**CNT_W - 1), so four spare bits suffice
   if (STATE_W < CNT_W + 4) begin : g_bad_state
      $error("cpu_execution_state_timing: STATE_W too narrow for sum");
   end

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Lead byte matches either code of a page pair
   function automatic logic lead_is(input logic [7:0] lead,
                                    input logic [7:0] code_a,
                                    input logic [7:0] code_b);
      return (lead == code_a) || (lead == code_b);
   endfunction

   // States per data access cycle at its location
   // Slow flag ignored on RAM, so a stale flag can't add a state
   function automatic logic [1:0] loc_states(input logic periph,
                                             input logic slow);
      logic [1:0] n;
      n = exec_timing_pkg::STATES_MEM;
      if (periph && slow) begin
         n = exec_timing_pkg::STATES_PERIPH_3;
      end else if (periph) begin
         n = exec_timing_pkg::STATES_PERIPH_2;
      end
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Decode

   logic [7:0] byte1;
   logic [3:0] byte3_low;
   logic [3:0] fourth_byte_upper_nibble;
   logic       page_reg;
   logic       page_abs;

   always_comb begin
      byte1                    = code_i[31:24];
      byte3_low                = code_i[11:8];
      fourth_byte_upper_nibble = code_i[7:4];
      // Third byte low nibble qualifies the register page only
      page_reg = lead_is(byte1, exec_timing_pkg::PAGE_REG_A,
                         exec_timing_pkg::PAGE_REG_B) &&
                 (byte3_low == exec_timing_pkg::PAGE_LOW_NIB ||
                  byte3_low == exec_timing_pkg::PAGE_LOW_NIB_6 ||
                  byte3_low == exec_timing_pkg::PAGE_LOW_NIB_7);
      page_abs = lead_is(byte1, exec_timing_pkg::PAGE_ABS_A,
                         exec_timing_pkg::PAGE_ABS_B);
   end

   ////////////////////////////////////////////////////////////////////////
   // State count per category

   logic [1:0] s_fetch;
   logic [1:0] s_branch;
   logic [1:0] s_stack;
   logic [1:0] s_byte;
   logic [1:0] s_word;
   logic [1:0] s_int;

   always_comb begin
      // Fetch, branch and stack areas assumed in on-chip memory
      s_fetch  = exec_timing_pkg::STATES_MEM;
      s_branch = exec_timing_pkg::STATES_MEM;
      s_stack  = exec_timing_pkg::STATES_MEM;
      s_int    = exec_timing_pkg::STATES_INTERNAL;
      s_byte   = loc_states(data_periph_i, periph_slow_i);
      s_word   = loc_states(data_periph_i, periph_slow_i);
   end

   // Six categories, each its own product term
   logic [CNT_W-1:0]   cnt_vec [6];
   logic [1:0]         per_vec [6];
   logic [STATE_W-1:0] term    [6];

   always_comb begin
      cnt_vec[0] = fetch_cnt_i;
      cnt_vec[1] = branch_cnt_i;
      cnt_vec[2] = stack_cnt_i;
      cnt_vec[3] = byte_cnt_i;
      cnt_vec[4] = word_cnt_i;
      cnt_vec[5] = internal_cnt_i;
      per_vec[0] = s_fetch;
      per_vec[1] = s_branch;
      per_vec[2] = s_stack;
      per_vec[3] = s_byte;
      per_vec[4] = s_word;
      per_vec[5] = s_int;
   end

   // Products kept apart so each multiplier stays narrow
   for (genvar g = 0; g < 6; g++) begin : g_term
      state_term #(
         .CNT_W   (CNT_W),
         .STATE_W (STATE_W)
      ) u_term (
         .cycles_i    (cnt_vec[g]),
         .per_cycle_i (per_vec[g]),
         .states_o    (term[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Next values and registers

   logic                     valid_nxt,   valid_r;
   logic                     page_nxt,    page_r;
   logic                     grp_nxt,     grp_r;
   logic [1:0]               kind_nxt,    kind_r;
   logic [3:0]               reg_nxt,     reg_r;
   logic [7:0]               abs_nxt,     abs_r;
   logic [STATE_W-1:0]       states_nxt,  states_r;

   // Fields only move on an accepted code; otherwise they hold
   always_comb begin
      valid_nxt  = code_valid_i;
      page_nxt   = page_r;
      grp_nxt    = grp_r;
      kind_nxt   = kind_r;
      reg_nxt    = reg_r;
      abs_nxt    = abs_r;
      states_nxt = states_r;
      if (code_valid_i) begin
         page_nxt = page_reg || page_abs;
         grp_nxt  = fourth_byte_upper_nibble[3];
         kind_nxt = exec_timing_pkg::OPND_NONE;
         reg_nxt  = 4'h0;
         abs_nxt  = 8'h00;
         if (page_reg) begin
            kind_nxt = exec_timing_pkg::OPND_REG;
            reg_nxt  = code_i[exec_timing_pkg::REG_FIELD_LSB +:
                              exec_timing_pkg::REG_FIELD_W];
         end else if (page_abs) begin
            kind_nxt = exec_timing_pkg::OPND_ABS;
            abs_nxt  = code_i[exec_timing_pkg::ABS_FIELD_LSB +:
                              exec_timing_pkg::ABS_FIELD_W];
         end
         // Sum can't overflow: width checked at elaboration
         states_nxt = term[0] + term[1] + term[2] +
                      term[3] + term[4] + term[5];
      end
   end

   // Reset clears every result, so outputs read zero until a code
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         valid_r  <= 1'b0;
         page_r   <= 1'b0;
         grp_r    <= 1'b0;
         kind_r   <= exec_timing_pkg::OPND_NONE;
         reg_r    <= 4'h0;
         abs_r    <= 8'h00;
         states_r <= '0;
      end else begin
         valid_r  <= valid_nxt;
         page_r   <= page_nxt;
         grp_r    <= grp_nxt;
         kind_r   <= kind_nxt;
         reg_r    <= reg_nxt;
         abs_r    <= abs_nxt;
         states_r <= states_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, bare copies of the registers

   always_comb begin
      valid_o                  = valid_r;
      bit_page_o               = page_r;
      group_hi_o               = grp_r;
      opnd_kind_o              = kind_r;
      reg_num_o                = reg_r;
      absolute_address_field_o = abs_r;
      exec_states_o            = states_r;
   end

endmodule

/* File: verification/periph_map.sv */
`timescale 1ns/1ps
// Internal bus target: RAM below 80h, peripheral modules above
module periph_map (
   // Data access address
   input  wire logic [7:0] addr_i,
   // Location and wait class
   output logic            periph_o,
   output logic            slow_o
);
   // Wait class tied to address block, so fixed per module
   assign periph_o = addr_i[7];
   assign slow_o   = addr_i[7] & addr_i[4];
endmodule

/* File: verification/cpu_execution_state_timing_props.sv */
`timescale 1ns/1ps
module exec_timing_props #(
   parameter int CNT_W   = 4,
   parameter int STATE_W = 8
) (
   // Clock, reset, request
   input wire logic               mclk_i,
   input wire logic               rst_b_i,
   input wire logic               code_valid_i,
   input wire logic [31:0]        code_i,
   // Counts and location
   input wire logic [CNT_W-1:0]   fetch_cnt_i,
   input wire logic [CNT_W-1:0]   branch_cnt_i,
   input wire logic [CNT_W-1:0]   stack_cnt_i,
   input wire logic [CNT_W-1:0]   byte_cnt_i,
   input wire logic [CNT_W-1:0]   word_cnt_i,
   input wire logic [CNT_W-1:0]   internal_cnt_i,
   input wire logic               data_periph_i,
   input wire logic               periph_slow_i,
   // Results
   input wire logic               valid_o,
   input wire logic               bit_page_o,
   input wire logic               group_hi_o,
   input wire logic [1:0]         opnd_kind_o,
   input wire logic [3:0]         reg_num_o,
   input wire logic [7:0]         absolute_address_field_o,
   input wire logic [STATE_W-1:0] exec_states_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   wire logic [5:0] bus_n = fetch_cnt_i + branch_cnt_i + stack_cnt_i;
   wire logic [4:0] dat_n = byte_cnt_i + word_cnt_i;
   wire logic       lone  = internal_cnt_i == '0;
   sequence s_take; code_valid_i ##1 valid_o; endsequence
   sequence s_idle; !code_valid_i ##1 !valid_o; endsequence
   property p_ans; code_valid_i |-> s_take; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_idle;
      !code_valid_i |-> s_idle ##0 $stable(exec_states_o);
   endproperty
   a_idle: assert property (p_idle) else $error("not held");
   property p_grp; code_valid_i |=> group_hi_o == $past(code_i[7]);
   endproperty
   a_grp: assert property (p_grp) else $error("group");
   property p_reg; code_valid_i && code_i[31:25] == 7'h3E
      && code_i[19:8] == 12'h060 |=> opnd_kind_o == 2'h1
      && reg_num_o == $past(code_i[23:20]); endproperty
   a_reg: assert property (p_reg) else $error("reg field");
   property p_abs; code_valid_i && code_i[31:25] == 7'h3F |=>
      absolute_address_field_o == $past(code_i[23:16]); endproperty
   a_abs: assert property (p_abs) else $error("abs field");
   property p_mem; code_valid_i && dat_n == '0 && lone |=>
      exec_states_o == 8'h2 * $past(bus_n); endproperty
   a_mem: assert property (p_mem) else $error("fetch states");
   property p_ram; code_valid_i && !data_periph_i && bus_n == '0 && lone
      |=> exec_states_o == 8'h2 * $past(dat_n); endproperty
   a_ram: assert property (p_ram) else $error("ram states");
   property p_slow; code_valid_i && data_periph_i && periph_slow_i
      && bus_n == '0 && lone |=> exec_states_o == 8'h3 * $past(dat_n);
   endproperty
   a_slow: assert property (p_slow) else $error("periph");
   property p_int; code_valid_i && bus_n == '0 && dat_n == '0 |=>
      exec_states_o == $past(internal_cnt_i); endproperty
   a_int: assert property (p_int) else $error("internal");
   property p_page; code_valid_i && code_i[31:25] == 7'h3F |=>
      bit_page_o && opnd_kind_o == 2'h2; endproperty
   a_page: assert property (p_page) else $error("abs page");
   property p_nopage; code_valid_i && code_i[31:26] != 6'h1F |=>
      !bit_page_o && opnd_kind_o == 2'h0 && reg_num_o == 4'h0
      && absolute_address_field_o == 8'h00; endproperty
   a_nopage: assert property (p_nopage) else $error("no page");
   property p_fast; code_valid_i && data_periph_i && !periph_slow_i
      && bus_n == '0 && lone |=> exec_states_o == 8'h2 * $past(dat_n);
   endproperty
   a_fast: assert property (p_fast) else $error("fast periph");
endmodule
bind cpu_execution_state_timing exec_timing_props #(
   .CNT_W   (CNT_W),
   .STATE_W (STATE_W)
) u_props (
   .mclk_i                   (mclk_i),
   .rst_b_i                  (rst_b_i),
   .code_valid_i             (code_valid_i),
   .code_i                   (code_i),
   .fetch_cnt_i              (fetch_cnt_i),
   .branch_cnt_i             (branch_cnt_i),
   .stack_cnt_i              (stack_cnt_i),
   .byte_cnt_i               (byte_cnt_i),
   .word_cnt_i               (word_cnt_i),
   .internal_cnt_i           (internal_cnt_i),
   .data_periph_i            (data_periph_i),
   .periph_slow_i            (periph_slow_i),
   .valid_o                  (valid_o),
   .bit_page_o               (bit_page_o),
   .group_hi_o               (group_hi_o),
   .opnd_kind_o              (opnd_kind_o),
   .reg_num_o                (reg_num_o),
   .absolute_address_field_o (absolute_address_field_o),
   .exec_states_o            (exec_states_o)
);

/* File: verification/cpu_execution_state_timing_bench.sv */
`timescale 1ns/1ps
module cpu_execution_state_timing_bench;
   logic        mclk_i = 1'b0, rst_b_i = 1'b0, cv = 1'b0, pv = 1'b0;
   logic [31:0] code = 32'h0, pc = 32'h0, lc = 32'h0;
   logic [3:0]  cn [6] = '{default: 4'h0};
   logic [7:0]  addr = 8'h0;
   logic        dp, ds, vo, gh, bp;
   logic [1:0]  ok;
   logic [3:0]  rn;
   logic [7:0]  af, st;
   int          num_errors = 0, total_checks = 0, cyc = 0, ls = 0;
   int          q[$];
   always #2.5 mclk_i = ~mclk_i;
   periph_map pm (.addr_i(addr), .periph_o(dp), .slow_o(ds));
   cpu_execution_state_timing dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .code_valid_i(cv), .code_i(code), .fetch_cnt_i(cn[0]),
      .branch_cnt_i(cn[1]), .stack_cnt_i(cn[2]), .byte_cnt_i(cn[3]),
      .word_cnt_i(cn[4]), .internal_cnt_i(cn[5]), .data_periph_i(dp),
      .periph_slow_i(ds), .valid_o(vo), .bit_page_o(bp), .group_hi_o(gh),
      .opnd_kind_o(ok), .reg_num_o(rn), .absolute_address_field_o(af),
      .exec_states_o(st));
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   // Check previous answer, then launch next request
   task step(input logic v);
      int          k;
      logic [31:0] r;
      @(negedge mclk_i);
      if (pv) begin
         ls = q.pop_front();
         lc = pc;
      end
      // Register page needs third byte low nibble 0, 6 or 7
      k = (lc[31:25] == 7'h3E && (lc[11:8] == 4'h0 || lc[11:8] == 4'h6
           || lc[11:8] == 4'h7)) ? 1 : (lc[31:25] == 7'h3F ? 2 : 0);
      chk(vo, pv);
      chk(gh, lc[7]);
      chk(bp, k != 0);
      chk(ok, k);
      chk(rn, k == 1 ? lc[23:20] : 0);
      chk(af, k == 2 ? lc[23:16] : 0);
      chk(st, ls);
      r = $urandom;
      case ($urandom % 3)
         0: code = {24'h01C050, r[7:0]};
         1: code = {7'h3E, r[8], r[12:9], 4'h0, 3'h3, r[13],
                    (r[14] ? 4'h0 : r[18:15]), r[7:0]};
         default: code = {7'h3F, r[8], r[31:16], r[7:0]};
      endcase
      // Mostly zero counts so single categories get isolated
      foreach (cn[i]) cn[i] = ($urandom % 3) ? 4'h0 : 4'($urandom);
      addr = 8'($urandom);
      cv = v;
      #1;
      if (v) q.push_back(2 * (cn[0] + cn[1] + cn[2]) + cn[5]
         + ((dp && ds) ? 3 : 2) * (cn[3] + cn[4]));
      pc = code;
      pv = v;
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         give_verdict;
      end
   end
   initial begin
      void'($urandom(56630));
      repeat (2) @(negedge mclk_i);
      rst_b_i = 1'b1;
      repeat (400) step($urandom % 4 != 0);
      step(1'b0);
      step(1'b0);
      give_verdict;
   end
endmodule
